/* hw/emb_pkg.sv */
package emb_pkg;

  localparam int CLK_MHZ  = 200;
  // Instruction cycle time of the core that issues table operations
  localparam int TCY_NS   = 20;
  localparam int TCY_CLKS = (TCY_NS * CLK_MHZ + 999) / 1000;

  localparam int REG_ADDR_W = 4;
  localparam logic [REG_ADDR_W-1:0] REG_BUS_CTRL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS   = 4'h1;

  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] CTRL_MASK  = 8'hb3;
  localparam int         BUS_DIS_BIT = 7;
  localparam int         WAIT_LSB    = 4;
  localparam int         WM_LSB      = 0;
  localparam int         ST_BUSY_BIT = 7;

  localparam int J_ALE = 0;
  localparam int J_OE  = 1;
  localparam int J_WRL = 2;
  localparam int J_WRH = 3;
  localparam int J_BA0 = 4;
  localparam int J_CE  = 5;
  localparam int J_LB  = 6;
  localparam int J_UB  = 7;
  // Parked bus: active-low controls high, latch strobe and byte address low
  localparam logic [7:0] J_IDLE = 8'hee;

  localparam logic [7:0] E_MASK_A12 = 8'h0f;
  localparam logic [7:0] E_MASK_ALL = 8'hff;

  typedef enum logic [1:0] {
    EMB_A20 = 2'b00,
    EMB_A16 = 2'b01,
    EMB_A12 = 2'b10,
    EMB_MCU = 2'b11
  } emb_mode_t;

  localparam logic [1:0] WM_BYTE_WR = 2'b00;
  localparam logic [1:0] WM_BYTE_SEL = 2'b01;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_STRB = 3'b010,
    ST_WAIT = 3'b011,
    ST_DONE = 3'b100
  } emb_state_t;

  typedef struct packed {
    logic       cfg_done;
    logic       cfg_bw;
    emb_mode_t  cfg_mode;
    logic       cfg_wait;
    logic [7:0] ctrl;
    emb_state_t st;
    logic       op_wr;
    logic       op_lsb;
    logic [19:0] op_addr;
    logic [7:0] op_byte;
    logic [7:0] tl0;
    logic [7:0] rdata;
    logic       req_ready;
    logic       busy;
    logic       rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0] d_s1;
    logic [7:0] d_s2;
    logic [7:0] d_s3;
    logic [7:0] d_f;
    logic [7:0] e_s1;
    logic [7:0] e_s2;
    logic [7:0] e_s3;
    logic [7:0] e_f;
    logic [7:0] d_out;
    logic [7:0] d_oe;
    logic [7:0] e_out;
    logic [7:0] e_oe;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [7:0] j_out;
    logic [7:0] j_oe;
  } emb_top_state_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic [1:0] wcnt;
    logic       busy;
    logic       tick;
    logic       done;
  } emb_div_state_t;

endpackage

/* hw/emb_tick_if.sv */
`timescale 1ns/1ps
interface emb_tick_if;
  logic       tick;
  logic       start;
  logic [1:0] waits;
  logic       done;
  modport ctl (input tick, input done, output start, output waits);
  modport div (output tick, output done, input start, input waits);
endinterface // emb_tick_if

/* hw/emb_tcy_div.sv */
`timescale 1ns/1ps
module emb_tcy_div
  import emb_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  emb_tick_if.div   tk
);

  emb_div_state_t s_q;
  emb_div_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    s_d.done = 1'b0;
    if (s_q.cnt == 2'(TCY_CLKS - 1)) begin
      s_d.cnt  = 2'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 2'h1;
    end
    // Wait cycles are whole instruction cycles counted on the tick
    if (tk.start) begin
      if (tk.waits == 2'h0) begin
        s_d.done = 1'b1;
      end else begin
        s_d.busy = 1'b1;
        s_d.wcnt = tk.waits;
      end
    end else if (s_q.busy && s_q.tick) begin
      s_d.wcnt = s_q.wcnt - 2'h1;
      if (s_q.wcnt == 2'h1) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.tick = s_q.tick;
  assign tk.done = s_q.done;

endmodule // emb_tcy_div

/* hw/emb_top.sv */
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module emb_top
  import emb_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  cfg_data_width,
  input  wire logic [1:0]            cfg_memory_mode_width,
  input  wire logic                  cfg_wait_enable,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic [19:0]           req_addr,
  input  wire logic                  req_byte_lsb,
  input  wire logic [7:0]            req_table_latch,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic      [15:0]           rsp_rdata,
  output logic                       bus_busy,
  input  wire logic [7:0]            gpio_d_out,
  input  wire logic [7:0]            gpio_d_oe,
  input  wire logic [7:0]            gpio_e_out,
  input  wire logic [7:0]            gpio_e_oe,
  input  wire logic [3:0]            gpio_h_out,
  input  wire logic [3:0]            gpio_h_oe,
  input  wire logic [7:0]            gpio_j_out,
  input  wire logic [7:0]            gpio_j_oe,
  input  wire logic [7:0]            port_d_a_in,
  input  wire logic [7:0]            port_e_b_in,
  output logic      [7:0]            port_d_a_out,
  output logic      [7:0]            port_d_a_oe,
  output logic      [7:0]            port_e_b_out,
  output logic      [7:0]            port_e_b_oe,
  output logic      [3:0]            port_h_c_out,
  output logic      [3:0]            port_h_c_oe,
  output logic      [7:0]            port_j_d_out,
  output logic      [7:0]            port_j_d_oe
);

  ////////////////////////////////////////////////////////////////////////////

  emb_top_state_t s_q;
  emb_top_state_t s_d;
  emb_tick_if     tk ();

  emb_tcy_div u_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .tk      (tk)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic       ext_mode;
  logic       wide;
  logic       word_mode;
  logic       op_active;
  logic       own;
  logic [7:0] e_mask;
  logic [3:0] h_mask;
  logic [7:0] bus_d;
  logic [7:0] bus_d_oe;
  logic [7:0] bus_e;
  logic [7:0] bus_e_oe;
  logic [7:0] bus_j;
  logic [1:0] wm;
  logic       start;

  always_comb begin
    ext_mode  = s_q.cfg_done && (s_q.cfg_mode != EMB_MCU);
    wide      = s_q.cfg_bw;
    wm        = s_q.ctrl[WM_LSB +: 2];
    word_mode = wide && wm[1];
    op_active = (s_q.st == ST_ADDR) || (s_q.st == ST_STRB) || (s_q.st == ST_WAIT);
    own       = ext_mode && (!s_q.ctrl[BUS_DIS_BIT] || op_active);
    // narrow address widths hand the top lines back to the ports
    e_mask    = (s_q.cfg_mode == EMB_A12) ? E_MASK_A12 : E_MASK_ALL;
    h_mask    = (s_q.cfg_mode == EMB_A20) ? 4'hf : 4'h0;
  end

  // Bus-side pin values, before ownership is applied
  always_comb begin
    bus_d    = s_q.op_addr[7:0];
    bus_e    = s_q.op_addr[15:8];
    bus_d_oe = 8'h00;
    bus_e_oe = 8'h00;
    bus_j    = J_IDLE;
    case (s_q.st)
      ST_ADDR: begin
        // Address on every multiplexed line while the latch strobe is high
        bus_d_oe     = 8'hff;
        bus_e_oe     = 8'hff;
        bus_j[J_ALE] = 1'b1;
        bus_j[J_CE]  = 1'b0;
        bus_j[J_BA0] = s_q.op_lsb;
      end
      ST_STRB, ST_WAIT: begin
        bus_j[J_CE]  = 1'b0;
        bus_j[J_BA0] = s_q.op_lsb;
        // 8-bit width keeps the upper address on port E throughout
        bus_e_oe     = wide ? 8'h00 : 8'hff;
        if (!s_q.op_wr) begin
          bus_j[J_OE] = 1'b0;
        end else if (!wide) begin
          // Narrow bus: one byte on the low lines, the write mode has no say
          bus_d        = s_q.op_byte;
          bus_d_oe     = 8'hff;
          bus_j[J_WRL] = 1'b0;
        end else begin
          bus_d_oe = 8'hff;
          bus_e_oe = 8'hff;
          if (word_mode) begin
            bus_d        = s_q.tl0;
            bus_e        = s_q.op_byte;
            bus_j[J_WRH] = 1'b0;
          end else if (wm == WM_BYTE_SEL) begin
            bus_d        = s_q.op_byte;
            bus_e        = s_q.op_byte;
            bus_j[J_WRH] = 1'b0;
            if (s_q.op_lsb) begin
              bus_j[J_UB] = 1'b0;
            end else begin
              bus_j[J_LB] = 1'b0;
            end
          end else begin
            bus_d = s_q.op_byte;
            bus_e = s_q.op_byte;
            if (s_q.op_lsb) begin
              bus_j[J_WRH] = 1'b0;
            end else begin
              bus_j[J_WRL] = 1'b0;
            end
          end
        end
      end
      default: begin
        bus_j = J_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d           = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.rdata     = 8'h00;
    start         = 1'b0;

    // Straps are caught once after reset release and then frozen
    if (!s_q.cfg_done) begin
      s_d.cfg_done = 1'b1;
      s_d.cfg_bw   = cfg_data_width;
      s_d.cfg_mode = emb_mode_t'(cfg_memory_mode_width);
      s_d.cfg_wait = cfg_wait_enable;
    end

    // Pin inputs: three stages, a change is taken when the last two agree
    s_d.d_s1 = port_d_a_in;
    s_d.d_s2 = s_q.d_s1;
    s_d.d_s3 = s_q.d_s2;
    s_d.e_s1 = port_e_b_in;
    s_d.e_s2 = s_q.e_s1;
    s_d.e_s3 = s_q.e_s2;
    for (int i = 0; i < 8; i++) begin
      if (s_q.d_s2[i] == s_q.d_s3[i]) begin
        s_d.d_f[i] = s_q.d_s3[i];
      end
      if (s_q.e_s2[i] == s_q.e_s3[i]) begin
        s_d.e_f[i] = s_q.e_s3[i];
      end
    end

    // Writes before the straps are caught are dropped: the mode is not known yet
    if (reg_wr && (reg_addr == REG_BUS_CTRL) && ext_mode) begin
      s_d.ctrl = reg_wdata & CTRL_MASK;
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_BUS_CTRL: s_d.rdata = s_q.ctrl & CTRL_MASK;
        REG_STATUS: begin
          s_d.rdata[1:0]         = s_q.cfg_mode;
          s_d.rdata[2]           = s_q.cfg_bw;
          s_d.rdata[3]           = s_q.cfg_wait;
          s_d.rdata[6:4]         = 3'h0;
          s_d.rdata[ST_BUSY_BIT] = op_active;
        end
        default: begin
          // Unmapped offsets read zero; writes to them are dropped
          s_d.rdata = 8'h00;
        end
      endcase
    end

    case (s_q.st)
      ST_IDLE: begin
        // Ready rises on the first idle clock after reset and together with each answer
        s_d.req_ready = 1'b1;
        if (req_valid && s_q.req_ready) begin
          s_d.op_wr     = req_write;
          s_d.op_addr   = req_addr;
          s_d.op_lsb    = req_byte_lsb;
          s_d.op_byte   = req_table_latch;
          s_d.req_ready = 1'b0;
          if (!ext_mode) begin
            s_d.rsp_data = 16'h0000;
            s_d.st       = ST_DONE;
          end else if (req_write && word_mode && !req_byte_lsb) begin
            // First latch byte only waits for its partner
            s_d.tl0      = req_table_latch;
            s_d.rsp_data = 16'h0000;
            s_d.st       = ST_DONE;
          end else begin
            s_d.st = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        // Address phase runs to the next instruction-cycle boundary
        if (tk.tick) begin
          s_d.st = ST_STRB;
        end
      end
      ST_STRB: begin
        // Strobe phase closes the operation's own cycle before waits start
        if (tk.tick) begin
          start  = 1'b1;
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tk.done) begin
          s_d.rsp_data = 16'h0000;
          s_d.st       = ST_DONE;
        end
      end
      ST_DONE: begin
        // Read data is taken a clock after the wait phase, once the pad
        // synchroniser has caught what the memory drove under the strobe
        if (ext_mode && !s_q.op_wr) begin
          if (wide) begin
            s_d.rsp_data = {s_q.e_f, s_q.d_f};
          end else begin
            s_d.rsp_data = {8'h00, s_q.d_f};
          end
          if (wide && (s_q.cfg_mode == EMB_A12)) begin
            s_d.rsp_data[15:12] = 4'h0;
          end
        end
        s_d.rsp_valid = 1'b1;
        s_d.req_ready = 1'b1;
        s_d.st        = ST_IDLE;
      end
      default: begin
        s_d.st        = ST_IDLE;
        s_d.req_ready = 1'b1;
      end
    endcase

    // Pin ownership, one register stage before the pads
    if (own) begin
      s_d.d_out = bus_d;
      s_d.d_oe  = bus_d_oe;
      s_d.e_out = (e_mask & bus_e) | (~e_mask & gpio_e_out);
      s_d.e_oe  = (e_mask & bus_e_oe) | (~e_mask & gpio_e_oe);
      s_d.h_out = (h_mask & s_q.op_addr[19:16]) | (~h_mask & gpio_h_out);
      s_d.h_oe  = (h_mask & {4{bus_d_oe[0] && (s_q.st == ST_ADDR || !wide)}})
                  | (~h_mask & gpio_h_oe);
      s_d.j_out = bus_j;
      s_d.j_oe  = 8'hff;
    end else begin
      // Handed-back pins follow the port registers one clock later
      s_d.d_out = gpio_d_out;
      s_d.d_oe  = gpio_d_oe;
      s_d.e_out = gpio_e_out;
      s_d.e_oe  = gpio_e_oe;
      s_d.h_out = gpio_h_out;
      s_d.h_oe  = gpio_h_oe;
      s_d.j_out = gpio_j_out;
      s_d.j_oe  = gpio_j_oe;
    end

    // Busy is kept as its own register so the output needs no decode
    s_d.busy = (s_d.st != ST_IDLE);
  end

  // code 11 is no wait, 00 the most; inversion gives the count
  assign tk.waits = s_q.cfg_wait ? ~s_q.ctrl[WAIT_LSB +: 2] : 2'h0;
  assign tk.start = start;

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q           <= '0;
      s_q.cfg_bw    <= 1'b1;
      s_q.cfg_mode  <= EMB_MCU;
      s_q.ctrl      <= CTRL_RST;
      s_q.st        <= ST_IDLE;
      s_q.j_out     <= J_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata    = s_q.rdata;
  assign req_ready    = s_q.req_ready;
  assign rsp_valid    = s_q.rsp_valid;
  assign rsp_rdata    = s_q.rsp_data;
  assign bus_busy     = s_q.busy;
  assign port_d_a_out = s_q.d_out;
  assign port_d_a_oe  = s_q.d_oe;
  assign port_e_b_out = s_q.e_out;
  assign port_e_b_oe  = s_q.e_oe;
  assign port_h_c_out = s_q.h_out;
  assign port_h_c_oe  = s_q.h_oe;
  assign port_j_d_out = s_q.j_out;
  assign port_j_d_oe  = s_q.j_oe;

endmodule // emb_top

/* tb/emb_top_asserts.sv */
`timescale 1ns/1ps
module emb_top_chk
  import emb_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [1:0]  cfg_memory_mode_width,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic        bus_busy,
  input wire logic [7:0]  gpio_e_out,
  input wire logic [3:0]  gpio_h_out,
  input wire logic [3:0]  gpio_h_oe,
  input wire logic [7:0]  gpio_j_out,
  input wire logic [7:0]  gpio_j_oe,
  input wire logic [7:0]  port_d_a_oe,
  input wire logic [7:0]  port_e_b_out,
  input wire logic [3:0]  port_h_c_out,
  input wire logic [3:0]  port_h_c_oe,
  input wire logic [7:0]  port_j_d_out,
  input wire logic [7:0]  port_j_d_oe
);
  logic [1:0] up_q;
  logic       mcu;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // Straps stay put after reset, so the live pins stand for the latched copy
  assign mcu = (up_q == 2'h3) && (cfg_memory_mode_width == EMB_MCU);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_mcu2; mcu ##1 mcu; endsequence
  // Pins lag state by one clock, so ownership needs two busy cycles
  sequence s_own; cfg_memory_mode_width != EMB_MCU && bus_busy ##1 bus_busy; endsequence
  ////////////////////////////////////////
  a_ctrl_unimp: assert property (
    reg_rd && reg_addr == REG_BUS_CTRL |=> (reg_rdata & 8'h4c) == 8'h00)
    else $error("control reserved bits not zero");
  a_mcu_pins: assert property (
    s_mcu2 |-> port_j_d_out == $past(gpio_j_out) && port_j_d_oe == $past(gpio_j_oe))
    else $error("on-chip mode pins not ports");
  a_mcu_rsp: assert property (
    mcu && rsp_valid |-> rsp_rdata == 16'h0000)
    else $error("on-chip mode returned bus data");
  a_hi_free: assert property (
    up_q == 2'h3 && cfg_memory_mode_width != EMB_A20 |=>
      port_h_c_out == $past(gpio_h_out) && port_h_c_oe == $past(gpio_h_oe))
    else $error("unused high address pins not ports");
  a_nib_free: assert property (
    up_q == 2'h3 && cfg_memory_mode_width == EMB_A12 |=>
      (port_e_b_out & 8'hf0) == ($past(gpio_e_out) & 8'hf0))
    else $error("upper nibble of port e not a port");
  a_busy_owns: assert property (s_own |-> port_j_d_oe == 8'hff)
    else $error("control pins not owned during access");
  a_one_wr: assert property (
    s_own |-> port_j_d_out[J_WRL] || port_j_d_out[J_WRH])
    else $error("both write strobes active");
  a_ale_ce: assert property (
    s_own ##0 port_j_d_out[J_ALE] |-> !port_j_d_out[J_CE] && port_d_a_oe == 8'hff)
    else $error("address phase without chip enable or drive");
  a_rd_release: assert property (
    s_own ##0 !port_j_d_out[J_OE] |-> port_d_a_oe == 8'h00)
    else $error("data lines driven during read");
endmodule // emb_top_chk

bind emb_top emb_top_chk u_chk (
  .ref_clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .cfg_memory_mode_width, .rsp_valid,
  .rsp_rdata, .bus_busy, .gpio_e_out, .gpio_h_out, .gpio_h_oe, .gpio_j_out, .gpio_j_oe,
  .port_d_a_oe, .port_e_b_out, .port_h_c_out, .port_h_c_oe, .port_j_d_out, .port_j_d_oe
);

/* tb/emb_mem_model.sv */
`timescale 1ns/1ps
module emb_mem_model
  import emb_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [7:0]  d_out,
  input  wire logic [7:0]  e_out,
  input  wire logic [3:0]  h_out,
  input  wire logic [7:0]  j_out,
  input  wire logic [7:0]  j_oe,
  output logic      [7:0]  d_in,
  output logic      [7:0]  e_in,
  output logic      [19:0] addr_q,
  output logic      [3:0]  act_q,
  output logic      [15:0] wdat_q,
  output int               ops
);
  logic [15:0] drv_q = 16'h0000;
  logic        ale_q = 1'b0;
  initial ops = 0;
  initial act_q = 4'h0;
  initial addr_q = 20'h00000;
  // The memory answers its output enable without waiting for a clock edge
  assign {e_in, d_in} = (j_oe[J_OE] && !j_out[J_OE]) ? addr_q[15:0] ^ 16'hc3a5 : drv_q;
  always @(posedge ref_clk) begin
    ale_q <= j_oe[J_ALE] && j_out[J_ALE];
    if (j_oe[J_ALE] && j_out[J_ALE]) begin
      addr_q <= {h_out, e_out, d_out};
      act_q <= 4'h0;
      if (!ale_q) ops <= ops + 1;
    end
    if (j_oe[J_WRL] && (!j_out[J_WRL] || !j_out[J_WRH])) begin
      wdat_q <= {e_out, d_out};
      act_q <= act_q | ~{j_out[J_UB], j_out[J_LB], j_out[J_WRH], j_out[J_WRL]};
    end
    // Released lines toggle so a late sample never sees stale data
    drv_q <= ~drv_q;
  end
endmodule // emb_mem_model

/* tb/emb_top_tb.sv */
`timescale 1ns/1ps
module emb_top_tb
  import emb_pkg::*;
;
  logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, req_table_latch = 8'h00, reg_rdata;
  logic cfg_data_width = 1'b1, cfg_wait_enable = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [1:0] cfg_memory_mode_width = 2'h3;
  logic [19:0] req_addr = 20'h00000, m_addr;
  logic req_byte_lsb = 1'b0, req_ready, rsp_valid, bus_busy;
  logic [15:0] rsp_rdata, m_wdat;
  logic [7:0] gpio_d_out = 8'h00, gpio_d_oe = 8'h00, gpio_e_out = 8'h00, gpio_e_oe = 8'h00;
  logic [7:0] gpio_j_out = 8'h00, gpio_j_oe = 8'h00, port_d_a_in, port_e_b_in;
  logic [3:0] gpio_h_out = 4'h0, gpio_h_oe = 4'h0, port_h_c_out, port_h_c_oe, m_act;
  logic [7:0] port_d_a_out, port_d_a_oe, port_e_b_out, port_e_b_oe, port_j_d_out, port_j_d_oe;
  int n_fail = 0, num_checks = 0, m_ops;
  emb_top u_dut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cfg_data_width, .cfg_memory_mode_width, .cfg_wait_enable, .req_valid, .req_write,
    .req_addr, .req_byte_lsb, .req_table_latch, .req_ready, .rsp_valid, .rsp_rdata, .bus_busy,
    .gpio_d_out, .gpio_d_oe, .gpio_e_out, .gpio_e_oe, .gpio_h_out, .gpio_h_oe, .gpio_j_out,
    .gpio_j_oe, .port_d_a_in, .port_e_b_in, .port_d_a_out, .port_d_a_oe, .port_e_b_out,
    .port_e_b_oe, .port_h_c_out, .port_h_c_oe, .port_j_d_out, .port_j_d_oe);
  emb_mem_model u_mem (.ref_clk, .d_out(port_d_a_out), .e_out(port_e_b_out),
    .h_out(port_h_c_out), .j_out(port_j_d_out), .j_oe(port_j_d_oe), .d_in(port_d_a_in),
    .e_in(port_e_b_in), .addr_q(m_addr), .act_q(m_act), .wdat_q(m_wdat), .ops(m_ops));
  initial forever #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Straps are only latched after reset, so every mode change needs a fresh reset
  task automatic boot(input logic [1:0] m, input logic bw, input logic we);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    cfg_memory_mode_width <= m;
    cfg_data_width <= bw;
    cfg_wait_enable <= we;
    // Port copy of the output enable stays inactive so port traffic never looks like a read
    {gpio_d_out, gpio_d_oe, gpio_e_out, gpio_e_oe, gpio_h_out, gpio_h_oe, gpio_j_out,
     gpio_j_oe} <= 56'({$urandom, $urandom}) | 56'h200;
    cyc(5);
    arst_n <= 1'b1;
    cyc(3);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Strobe length counts from the read strobe to the response, free of tick phase
  task automatic op(input logic w, input logic [19:0] a, input logic l, input logic [7:0] b,
                    output logic [15:0] q, output int ol);
    int k;
    k = 0;
    ol = 0;
    @(posedge ref_clk);
    #1;
    while (req_ready !== 1'b1 && k < 300) begin
      @(posedge ref_clk);
      #1 k++;
    end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_byte_lsb <= l;
    req_table_latch <= b;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1 k++;
      if (ol > 0 || (port_j_d_oe[J_OE] && !port_j_d_out[J_OE])) ol++;
    end while (rsp_valid !== 1'b1 && k < 100);
    q = rsp_rdata;
    chk("response", 20'(k < 100), 20'h1);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0]  v;
    logic [7:0]  b;
    logic [3:0]  x;
    logic [15:0] q;
    logic [19:0] a;
    int          ol;
    int          o3;
    int          n;
    n = $urandom(47);
    boot(EMB_MCU, 1'b1, 1'b1);
    wr(REG_BUS_CTRL, 8'hb3);
    rd(REG_BUS_CTRL, v);
    chk("ctrl locked", 20'(v), 20'h0);
    op(1'b0, 20'h12345, 1'b0, 8'h00, q, ol);
    chk("mcu data", 20'(q), 20'h0);
    chk("mcu strobe", 20'(ol), 20'h0);
    $display("test on-chip done");
    boot(EMB_A20, 1'b1, 1'b1);
    rd(REG_BUS_CTRL, v);
    chk("ctrl reset", 20'(v), 20'h0);
    chk("port j own", 20'(port_j_d_oe), 20'hff);
    chk("port e idle", 20'(port_e_b_oe), 20'h0);
    wr(REG_STATUS, 8'h00);
    rd(REG_STATUS, v);
    chk("status", 20'(v & 8'h0f), 20'h0c);
    rd(4'hf, v);
    chk("unmapped", 20'(v), 20'h0);
    wr(REG_BUS_CTRL, 8'hff);
    rd(REG_BUS_CTRL, v);
    chk("ctrl mask", 20'(v), 20'hb3);
    cyc(2);
    #1 chk("port j gpio", 20'(port_j_d_oe), 20'(gpio_j_oe));
    for (int c = 3; c >= 0; c--) begin
      wr(REG_BUS_CTRL, 8'(8'h80 | (c << 4)));
      a = 20'($urandom);
      op(1'b0, a, 1'b0, 8'h00, q, ol);
      chk("rd data", 20'(q), 20'(a[15:0] ^ 16'hc3a5));
      chk("rd addr", m_addr, a);
      if (c == 3) o3 = ol;
      chk("wait", 20'(ol), 20'(o3 + TCY_CLKS * (3 - c)));
    end
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      wr(REG_BUS_CTRL, 8'(8'h30 | i[1]));
      op(1'b1, a, i[0], b, q, ol);
      x = i[1] ? (i[0] ? 4'ha : 4'h6) : (i[0] ? 4'h2 : 4'h1);
      chk("wr data", 20'(m_wdat), 20'({b, b}));
      chk("wr strobe", 20'(m_act & (i[1] ? 4'hf : 4'h3)), 20'(x));
    end
    wr(REG_BUS_CTRL, 8'h32);
    n = m_ops;
    op(1'b1, a, 1'b0, 8'h5a, q, ol);
    chk("word hold", 20'(m_ops), 20'(n));
    op(1'b1, a, 1'b1, 8'ha5, q, ol);
    chk("word data", 20'(m_wdat), 20'ha55a);
    chk("word strobe", 20'(m_act[1:0]), 20'h2);
    $display("test bus 20 bit done");
    boot(EMB_A12, 1'b1, 1'b0);
    chk("a12 e oe", 20'(port_e_b_oe & 8'hf0), 20'(gpio_e_oe & 8'hf0));
    op(1'b0, a, 1'b0, 8'h00, q, ol);
    chk("no wait", 20'(ol), 20'(o3));
    chk("a12 addr", 20'(m_addr[11:0]), 20'(a[11:0]));
    chk("a12 data", 20'(q), 20'((m_addr[15:0] ^ 16'hc3a5) & 16'h0fff));
    $display("test bus 12 bit done");
    boot(EMB_A16, 1'b0, 1'b1);
    chk("port h", 20'(port_h_c_oe), 20'(gpio_h_oe));
    wr(REG_BUS_CTRL, 8'h32);
    op(1'b1, a, 1'b1, 8'h3c, q, ol);
    chk("byte8 data", 20'(m_wdat[7:0]), 20'h3c);
    chk("byte8 strobe", 20'(m_act[1:0]), 20'h1);
    $display("test bus 8 bit done");
    stop_test();
  end
  initial begin
    cyc(20000);
    n_fail++;
    stop_test();
  end
endmodule // emb_top_tb
